// file: led_pwm_params.svh
// Constants of the LED dimming core: indices, reset values and timing counts
`ifndef LED_PWM_PARAMS_SVH
`define LED_PWM_PARAMS_SVH

// Internal setting indices written over the serial target port
`define IDX_BRIGHT_BASE    5'h00
`define IDX_GRP_DUTY       5'h10
`define IDX_GRP_FREQ       5'h11
`define IDX_MODE_BASE      5'h12
`define IDX_CONFIG         5'h16
`define IDX_GRP_ADDR       5'h17
`define IDX_SUB1_ADDR      5'h18
`define IDX_SUB2_ADDR      5'h19
`define IDX_SUB3_ADDR      5'h1a
`define NUM_SETTINGS       27

// Config field positions
`define CFG_BLINK          0
`define CFG_UPD_ACK        1
`define CFG_GRP_EN         2
`define CFG_SUB1_EN        3
`define CFG_SUB2_EN        4
`define CFG_SUB3_EN        5

// Reset values
`define RST_BRIGHT         8'h00
`define RST_GRP_DUTY       8'hff
`define RST_GRP_FREQ       8'h00
`define RST_MODE           8'h00
`define RST_CONFIG         8'h04
`define RST_GRP_ADDR       8'he0
`define RST_SUB1_ADDR      8'he2
`define RST_SUB2_ADDR      8'he4
`define RST_SUB3_ADDR      8'he8

// Bus addresses and the software reset call
`define HW_ADDR_PREFIX     3'h6
`define GEN_CALL_ADDR      7'h00
`define SOFT_RESET_DATA    8'h06

// Timing: rates in Hz, counts in ref_clk cycles
`define CLK_HZ             10000000
`define OSC_HZ             25000000
`define IND_PWM_HZ         97000
`define GRP_DIM_HZ         190
`define BLINK_MAX_HZ       24
`define PWM_STEPS          256
`define IND_STEP_RAW       (`CLK_HZ / (`IND_PWM_HZ * `PWM_STEPS))
`define IND_STEP_CYCLES    ((`IND_STEP_RAW < 1) ? 1 : `IND_STEP_RAW)
`define GRP_STEP_CYCLES    (`CLK_HZ / (`GRP_DIM_HZ * `PWM_STEPS))
`define BLINK_STEP_CYCLES  (`CLK_HZ / (`BLINK_MAX_HZ * `PWM_STEPS))

`endif

// file: led_pwm_pkg.sv
// Types shared by the LED dimming core and its serial target
package led_pwm_pkg;

    // Per-output drive selection
    typedef enum logic [1:0] {
        OUT_OFF = 2'b00,
        OUT_ON  = 2'b01,
        OUT_IND = 2'b10,
        OUT_GRP = 2'b11
    } out_mode_t;

    // Serial target byte state
    typedef enum logic [2:0] {
        I2C_IDLE = 3'b000,
        I2C_ADDR = 3'b001,
        I2C_DATA = 3'b010,
        I2C_ACK  = 3'b011,
        I2C_SKIP = 3'b100
    } i2c_state_t;

endpackage

// file: i2c_target_rx.sv
// Write-only serial bus target: framing, byte shifting and acknowledge
`timescale 1ns/1ps
module i2c_target_rx (
    // Clock and control
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    // Bus pins, sampled as synchronous
    input  wire logic       scl,
    input  wire logic       sda,
    output logic            sda_oe,
    // Byte side
    input  wire logic       ack_ok,
    output logic [7:0]      shift,
    output logic            addr_phase,
    output logic            byte_stb,
    output logic            byte_is_addr,
    output logic            stop_stb
);
    led_pwm_pkg::i2c_state_t state;
    led_pwm_pkg::i2c_state_t next_state;
    logic       scl_q;
    logic       sda_q;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] next_shift;
    logic       next_sda_oe;
    logic       next_byte_stb;
    logic       next_byte_is_addr;
    logic       next_stop_stb;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;

    // Bus conditions from the previous pin samples
    assign scl_rise   = scl && !scl_q;
    assign scl_fall   = !scl && scl_q;
    assign start_cond = scl && scl_q && sda_q && !sda;
    assign stop_cond  = scl && scl_q && !sda_q && sda;
    assign addr_phase = (state == led_pwm_pkg::I2C_ADDR);

    // Byte state machine; a refused address parks in skip until the next start or stop
    always_comb begin
        next_state        = state;
        next_bit_cnt      = bit_cnt;
        next_shift        = shift;
        next_sda_oe       = sda_oe;
        next_byte_stb     = 1'b0;
        next_byte_is_addr = byte_is_addr;
        next_stop_stb     = 1'b0;
        if (start_cond) begin
            next_state   = led_pwm_pkg::I2C_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe  = 1'b0;
        end else if (stop_cond) begin
            next_state    = led_pwm_pkg::I2C_IDLE;
            next_sda_oe   = 1'b0;
            next_stop_stb = 1'b1;
        end else begin
            case (state)
                led_pwm_pkg::I2C_ADDR, led_pwm_pkg::I2C_DATA: begin
                    if (scl_rise && bit_cnt != 4'h8) begin
                        next_shift   = {shift[6:0], sda};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        if (ack_ok) begin
                            next_sda_oe       = 1'b1;
                            next_byte_stb     = 1'b1;
                            next_byte_is_addr = addr_phase;
                            next_state        = led_pwm_pkg::I2C_ACK;
                        end else begin
                            next_state = led_pwm_pkg::I2C_SKIP;
                        end
                    end
                end
                led_pwm_pkg::I2C_ACK: begin
                    if (scl_fall) begin
                        next_sda_oe  = 1'b0;
                        next_bit_cnt = 4'h0;
                        next_state   = led_pwm_pkg::I2C_DATA;
                    end
                end
                led_pwm_pkg::I2C_IDLE, led_pwm_pkg::I2C_SKIP: begin
                    next_sda_oe = 1'b0;
                end
                default: begin
                    next_state = led_pwm_pkg::I2C_IDLE;
                end
            endcase
        end
    end

    // Registers; idle pins read high so no false start after reset
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state        <= led_pwm_pkg::I2C_IDLE;
            bit_cnt      <= 4'h0;
            shift        <= 8'h00;
            sda_oe       <= 1'b0;
            byte_stb     <= 1'b0;
            byte_is_addr <= 1'b0;
            stop_stb     <= 1'b0;
            scl_q        <= 1'b1;
            sda_q        <= 1'b1;
        end else if (clk_en) begin
            state        <= next_state;
            bit_cnt      <= next_bit_cnt;
            shift        <= next_shift;
            sda_oe       <= next_sda_oe;
            byte_stb     <= next_byte_stb;
            byte_is_addr <= next_byte_is_addr;
            stop_stb     <= next_stop_stb;
            scl_q        <= scl;
            sda_q        <= sda;
        end
    end
endmodule

// file: led_pwm_dimming_control.sv
// Sixteen-output LED dimming core: settings, individual and group modulators
`timescale 1ns/1ps
`include "led_pwm_params.svh"
module led_pwm_dimming_control #(
    parameter int NUM_OUT = 16
) (
    // Clock and resets
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    input  wire logic               clk_en,
    input  wire logic               rst_n,
    // Address straps
    input  wire logic [3:0]         hw_addr,
    // Serial bus pins
    input  wire logic               scl,
    input  wire logic               sda,
    output logic                    sda_oe,
    // LED sinks, low while sinking
    output logic [NUM_OUT-1:0]      led_sink_n
);
    logic [7:0]          live   [0:`NUM_SETTINGS-1];
    logic [7:0]          staged [0:`NUM_SETTINGS-1];
    logic [7:0]          next_live   [0:`NUM_SETTINGS-1];
    logic [7:0]          next_staged [0:`NUM_SETTINGS-1];
    logic [4:0]          ptr;
    logic [4:0]          next_ptr;
    logic                first_byte;
    logic                next_first_byte;
    logic                gen_call;
    logic                next_gen_call;
    logic                soft_rst;
    logic                next_soft_rst;
    logic                rst_all;
    logic                bus_rst;
    logic [7:0]          shift;
    logic                addr_phase;
    logic                byte_stb;
    logic                byte_is_addr;
    logic                stop_stb;
    logic                ack_ok;
    logic                addr_match;
    logic [6:0]          rx_addr;
    logic [7:0]          cfg;
    logic [3:0]          ind_pre;
    logic [3:0]          next_ind_pre;
    logic [7:0]          ind_cnt;
    logic [7:0]          next_ind_cnt;
    logic [15:0]         grp_pre;
    logic [15:0]         next_grp_pre;
    logic [7:0]          blink_sub;
    logic [7:0]          next_blink_sub;
    logic [7:0]          grp_cnt;
    logic [7:0]          next_grp_cnt;
    logic [15:0]         grp_limit;
    logic                grp_active;
    logic [NUM_OUT-1:0]  next_sink_n;

    // reset input folds into the core reset
    assign bus_rst = sys_rst || !rst_n;
    assign rst_all = bus_rst || soft_rst;
    assign cfg     = live[`IDX_CONFIG];
    assign rx_addr = shift[7:1];

    always_comb begin
        addr_match = !shift[0] && (rx_addr == {`HW_ADDR_PREFIX, hw_addr} || rx_addr == `GEN_CALL_ADDR
                     || (cfg[`CFG_GRP_EN]  && rx_addr == live[`IDX_GRP_ADDR][7:1])
                     || (cfg[`CFG_SUB1_EN] && rx_addr == live[`IDX_SUB1_ADDR][7:1])
                     || (cfg[`CFG_SUB2_EN] && rx_addr == live[`IDX_SUB2_ADDR][7:1])
                     || (cfg[`CFG_SUB3_EN] && rx_addr == live[`IDX_SUB3_ADDR][7:1]));
        ack_ok = addr_phase ? addr_match : 1'b1;
    end

    // Bus target keeps running through a soft reset so the call byte is acknowledged
    i2c_target_rx u_rx (
        .ref_clk      (ref_clk),
        .sys_rst      (bus_rst),
        .clk_en       (clk_en),
        .scl          (scl),
        .sda          (sda),
        .sda_oe       (sda_oe),
        .ack_ok       (ack_ok),
        .shift        (shift),
        .addr_phase   (addr_phase),
        .byte_stb     (byte_stb),
        .byte_is_addr (byte_is_addr),
        .stop_stb     (stop_stb)
    );

    // Setting writes: first data byte is the index, later bytes auto-increment
    always_comb begin
        logic wrote;
        wrote           = 1'b0;
        next_ptr        = ptr;
        next_first_byte = first_byte;
        next_gen_call   = gen_call;
        next_soft_rst   = 1'b0;
        for (int i = 0; i < `NUM_SETTINGS; i++) begin
            next_staged[i] = staged[i];
        end
        if (byte_stb && byte_is_addr) begin
            next_gen_call   = (rx_addr == `GEN_CALL_ADDR);
            next_first_byte = 1'b1;
        end else if (byte_stb && gen_call) begin
            next_soft_rst = (shift == `SOFT_RESET_DATA);
        end else if (byte_stb && first_byte) begin
            next_ptr        = shift[4:0];
            next_first_byte = 1'b0;
        end else if (byte_stb) begin
            if (ptr < 5'(`NUM_SETTINGS)) begin
                next_staged[ptr] = shift;
                wrote            = 1'b1;
            end
            next_ptr = (ptr >= 5'(`NUM_SETTINGS - 1)) ? 5'h00 : ptr + 5'h01;
        end
        // commit per byte or at stop
        for (int i = 0; i < `NUM_SETTINGS; i++) begin
            next_live[i] = (stop_stb || (wrote && cfg[`CFG_UPD_ACK])) ? next_staged[i] : live[i];
        end
    end

    // Setting registers with their reset values
    always_ff @(posedge ref_clk) begin
        if (rst_all) begin
            for (int i = 0; i < `NUM_SETTINGS; i++) begin
                live[i]   <= (i < 16) ? `RST_BRIGHT : `RST_MODE;
                staged[i] <= (i < 16) ? `RST_BRIGHT : `RST_MODE;
            end
            live[`IDX_GRP_DUTY]    <= `RST_GRP_DUTY;
            staged[`IDX_GRP_DUTY]  <= `RST_GRP_DUTY;
            live[`IDX_GRP_FREQ]    <= `RST_GRP_FREQ;
            staged[`IDX_GRP_FREQ]  <= `RST_GRP_FREQ;
            live[`IDX_CONFIG]      <= `RST_CONFIG;
            staged[`IDX_CONFIG]    <= `RST_CONFIG;
            live[`IDX_GRP_ADDR]    <= `RST_GRP_ADDR;
            staged[`IDX_GRP_ADDR]  <= `RST_GRP_ADDR;
            live[`IDX_SUB1_ADDR]   <= `RST_SUB1_ADDR;
            staged[`IDX_SUB1_ADDR] <= `RST_SUB1_ADDR;
            live[`IDX_SUB2_ADDR]   <= `RST_SUB2_ADDR;
            staged[`IDX_SUB2_ADDR] <= `RST_SUB2_ADDR;
            live[`IDX_SUB3_ADDR]   <= `RST_SUB3_ADDR;
            staged[`IDX_SUB3_ADDR] <= `RST_SUB3_ADDR;
            ptr        <= 5'h00;
            first_byte <= 1'b0;
            gen_call   <= 1'b0;
            soft_rst   <= 1'b0;
        end else if (clk_en) begin
            for (int i = 0; i < `NUM_SETTINGS; i++) begin
                live[i]   <= next_live[i];
                staged[i] <= next_staged[i];
            end
            ptr        <= next_ptr;
            first_byte <= next_first_byte;
            gen_call   <= next_gen_call;
            soft_rst   <= next_soft_rst;
        end
    end

    // all modulator timing from one clock; at 10 MHz the step is one cycle
    // so the individual period is 25.6 us rather than the oscillator-based one
    always_comb begin
        next_ind_pre = ind_pre;
        next_ind_cnt = ind_cnt;
        if (ind_pre == 4'(`IND_STEP_CYCLES - 1)) begin
            next_ind_pre = 4'h0;
            next_ind_cnt = ind_cnt + 8'h01;
        end else begin
            next_ind_pre = ind_pre + 4'h1;
        end
    end

    // dim step fixed; blink step scaled by the frequency setting
    always_comb begin
        grp_limit      = cfg[`CFG_BLINK] ? 16'(`BLINK_STEP_CYCLES - 1) : 16'(`GRP_STEP_CYCLES - 1);
        next_grp_pre   = grp_pre + 16'h0001;
        next_blink_sub = blink_sub;
        next_grp_cnt   = grp_cnt;
        if (grp_pre >= grp_limit) begin
            next_grp_pre = 16'h0000;
            if (cfg[`CFG_BLINK] && blink_sub < live[`IDX_GRP_FREQ]) begin
                next_blink_sub = blink_sub + 8'h01;
            end else begin
                next_blink_sub = 8'h00;
                next_grp_cnt   = grp_cnt + 8'h01;
            end
        end
    end

    // one group phase for all following outputs
    assign grp_active = (grp_cnt < live[`IDX_GRP_DUTY]);

    always_comb begin
        logic [1:0] m;
        logic       on;
        m  = 2'b00;
        on = 1'b0;
        for (int i = 0; i < NUM_OUT; i++) begin
            m  = live[5'(`IDX_MODE_BASE + i / 4)][2 * (i % 4) +: 2];
            on = 1'b0;
            case (led_pwm_pkg::out_mode_t'(m))
                led_pwm_pkg::OUT_OFF: on = 1'b0;
                led_pwm_pkg::OUT_ON:  on = 1'b1;
                led_pwm_pkg::OUT_IND: on = (ind_cnt < live[i]);
                led_pwm_pkg::OUT_GRP: on = (ind_cnt < live[i]) && grp_active;
                default:              on = 1'b0;
            endcase
            next_sink_n[i] = !on;
        end
    end

    // Modulator counters and registered sinks
    always_ff @(posedge ref_clk) begin
        if (rst_all) begin
            ind_pre   <= 4'h0;
            ind_cnt   <= 8'h00;
            grp_pre   <= 16'h0000;
            blink_sub <= 8'h00;
            grp_cnt   <= 8'h00;
            led_sink_n <= '1;
        end else if (clk_en) begin
            ind_pre    <= next_ind_pre;
            ind_cnt    <= next_ind_cnt;
            grp_pre    <= next_grp_pre;
            blink_sub  <= next_blink_sub;
            grp_cnt    <= next_grp_cnt;
            led_sink_n <= next_sink_n;
        end
    end

    // Checks on reset, the soft reset call, channel 0, the shared counters and the stop commit
    logic [1:0] mode0;
    assign mode0 = live[`IDX_MODE_BASE][1:0];

    chk_reset_sinks_high: assert property (@(posedge ref_clk) rst_all |=> led_sink_n == '1)
        else $error("sinks not released after reset");
    chk_reset_group_full: assert property (@(posedge ref_clk) rst_all |=> live[`IDX_GRP_DUTY] == 8'hff)
        else $error("group duty not full after reset");
    chk_reset_bright_off: assert property (@(posedge ref_clk) rst_all |=> live[0] == 8'h00 && staged[5] == 8'h00)
        else $error("brightness not off after reset");
    chk_soft_reset_call: assert property (@(posedge ref_clk) disable iff (bus_rst)
        (clk_en && byte_stb && gen_call && !byte_is_addr && shift == 8'h06) |=> soft_rst ##1 led_sink_n == '1)
        else $error("soft reset call not honoured");
    chk_off_mode_high: assert property (@(posedge ref_clk) disable iff (rst_all)
        (clk_en && mode0 == 2'b00) |=> led_sink_n[0])
        else $error("off output sinking");
    chk_on_mode_low: assert property (@(posedge ref_clk) disable iff (rst_all)
        (clk_en && mode0 == 2'b01) |=> !led_sink_n[0])
        else $error("on output not sinking");
    chk_combined_and: assert property (@(posedge ref_clk) disable iff (rst_all)
        (clk_en && mode0 == 2'b11) |=> led_sink_n[0] == !($past(ind_cnt) < $past(live[0]) && $past(grp_active)))
        else $error("combined output not AND of modulators");
    chk_ind_period: assert property (@(posedge ref_clk) disable iff (rst_all || !clk_en)
        (ind_cnt == 8'h00 && $past(ind_cnt) == 8'hff) |-> ##256 ind_cnt == 8'h00)
        else $error("individual period not 256 steps");
    chk_dim_step: assert property (@(posedge ref_clk) disable iff (rst_all || !clk_en || cfg[`CFG_BLINK])
        $changed(grp_cnt) |-> ##205 $changed(grp_cnt))
        else $error("group dim step wrong");
    chk_stop_commit: assert property (@(posedge ref_clk) disable iff (rst_all)
        (clk_en && !stop_stb && !cfg[`CFG_UPD_ACK] && !$past(soft_rst)) |=> live[1] == $past(live[1]))
        else $error("setting applied before stop");

    // blink step is longer than any plain delay, so the gap is counted here
    logic [7:0]  grp_cnt_q;
    logic [23:0] blink_gap;
    logic        gap_seen;
    always_ff @(posedge ref_clk) begin
        if (rst_all || !cfg[`CFG_BLINK]) begin
            grp_cnt_q <= grp_cnt;
            blink_gap <= 24'h000000;
            gap_seen  <= 1'b0;
        end else if (clk_en) begin
            grp_cnt_q <= grp_cnt;
            blink_gap <= (grp_cnt != grp_cnt_q) ? 24'h000001 : blink_gap + 24'h000001;
            gap_seen  <= gap_seen || (grp_cnt != grp_cnt_q);
        end
    end

    chk_blink_step: assert property (@(posedge ref_clk) disable iff (rst_all)
        (clk_en && cfg[`CFG_BLINK] && gap_seen && grp_cnt != grp_cnt_q)
        |-> blink_gap == 24'(`BLINK_STEP_CYCLES) * (24'(live[`IDX_GRP_FREQ]) + 24'h000001))
        else $error("group blink step wrong");
endmodule

// file: i2c_host_model.sv
// Bus controller model: drives SCL and pulls SDA low for write transfers
`timescale 1ns/1ps
module i2c_host_model (
    // Clock
    input  wire logic ref_clk,
    // Device pull-down on the data line
    input  wire logic sda_oe,
    // Resolved bus lines
    output logic      scl,
    output logic      sda
);
    logic pull_low;
    int   half;

    // Pull-up wire: low while either party pulls, so a released line reads high
    assign sda = ~(pull_low | sda_oe);

    // Idle bus; half is raised by the bench for a slow controller
    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
        half = 4;
    end

    // Every change lands just after a clock edge
    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Start or repeated start: data falls while the clock is high
    task automatic start_cond();
        pull_low = 1'b0;
        hold(half);
        scl = 1'b1;
        hold(half);
        pull_low = 1'b1;
        hold(half);
        scl = 1'b0;
        hold(half);
    endtask

    // Eight bits MSB first, then the acknowledge slot with the line released
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            pull_low = ~b[i];
            hold(half);
            scl = 1'b1;
            hold(half);
            scl = 1'b0;
            hold(1);
        end
        pull_low = 1'b0;
        hold(half);
        scl = 1'b1;
        hold(half);
        ack = ~sda;
        scl = 1'b0;
        hold(1);
    endtask

    // Stop: data rises while the clock is high
    task automatic stop_cond();
        pull_low = 1'b1;
        hold(half);
        scl = 1'b1;
        hold(half);
        pull_low = 1'b0;
        hold(half);
    endtask

    // Address, index and one data byte; ok only if all three were acknowledged
    task automatic write_reg(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d, output logic ok);
        logic k1, k2, k3;
        start_cond();
        send_byte({a, 1'b0}, k1);
        send_byte(idx, k2);
        send_byte(d, k3);
        stop_cond();
        ok = k1 & k2 & k3;
    endtask

    // general call carrying the reset byte
    task automatic soft_reset_call();
        logic k;
        start_cond();
        send_byte(8'h00, k);
        send_byte(8'h06, k);
        stop_cond();
    endtask
endmodule

// file: led_pwm_dimming_control_tb.sv
// Self-checking bench for the LED dimming core driven by a bus controller model
`timescale 1ns/1ps
`include "led_pwm_params.svh"
module led_pwm_dimming_control_tb;
    typedef struct {logic [7:0] idx; logic [7:0] data; int out; int exp;} row_t;
    logic        ref_clk, sys_rst, clk_en, rst_n, scl, sda, sda_oe, ack;
    logic [3:0]  hw_addr;
    logic [6:0]  own;
    logic [15:0] led_sink_n;
    int          mismatches, num_checks, frz;
    logic [15:0] held;
    // Setting index, value, output watched, expected sinking cycles per 256
    row_t rows[6] = '{'{8'h02, 8'h40, 2, 0}, '{8'h12, 8'he4, 2, 'h40}, '{8'h12, 8'he4, 1, 256},
                      '{8'h12, 8'he4, 0, 0}, '{8'h03, 8'hc0, 3, 'hc0}, '{8'h10, 8'h00, 3, 0}};

    assign own = {`HW_ADDR_PREFIX, hw_addr};

    led_pwm_dimming_control #(.NUM_OUT(16)) DUT (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .rst_n(rst_n), .hw_addr(hw_addr),
        .scl(scl), .sda(sda), .sda_oe(sda_oe), .led_sink_n(led_sink_n));
    i2c_host_model host (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

    always #50 ref_clk = ~ref_clk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Sinking cycles over one full individual period equal the duty value
    task automatic duty(input int n, input int exp);
        int c;
        c = 0;
        repeat (4) @(posedge ref_clk);
        repeat (`PWM_STEPS) begin
            @(posedge ref_clk);
            #1;
            if (led_sink_n[n] === 1'b0) c++;
        end
        check(c, exp);
    endtask

    // Open a write to the own address up to the data byte, bus left held
    task automatic open_write(input logic [7:0] idx, input logic [7:0] d);
        host.start_cond();
        host.send_byte({own, 1'b0}, ack);
        host.send_byte(idx, ack);
        host.send_byte(d, ack);
    endtask

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog well beyond the roughly 13k cycles the tests need
    initial begin
        #5000000;
        mismatches++;
        $display("watchdog expired");
        stop_test();
    end

    initial begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        rst_n = 1'b1;
        hw_addr = 4'h5;
        mismatches = 0;
        num_checks = 0;
        repeat (12) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        check(led_sink_n, 16'hffff);
        check(sda_oe, 1'b0);
        $display("reset test done");
        // Table: modes, individual duty, group AND with default full duty
        foreach (rows[i]) begin
            host.write_reg(own, rows[i].idx, rows[i].data, ack);
            check(ack, 1'b1);
            duty(rows[i].out, rows[i].exp);
            $display("row %0d done", i);
        end
        // default: nothing applies before the stop
        open_write(8'h02, 8'h20);
        duty(2, 'h40);
        host.stop_cond();
        duty(2, 'h20);
        // update on acknowledge, group address enabled as well
        host.write_reg(own, 8'h16, 8'h06, ack);
        open_write(8'h02, 8'h10);
        duty(2, 'h10);
        host.stop_cond();
        $display("update timing test done");
        // group call answered, disabled sub-call ignored
        host.write_reg(`RST_GRP_ADDR >> 1, 8'h02, 8'h08, ack);
        check(ack, 1'b1);
        duty(2, 'h08);
        host.write_reg(`RST_SUB1_ADDR >> 1, 8'h02, 8'h50, ack);
        check(ack, 1'b0);
        duty(2, 'h08);
        $display("call address test done");
        // straps move the address; a slow controller this time
        host.half = 8;
        hw_addr = 4'ha;
        host.write_reg(7'h65, 8'h02, 8'h50, ack);
        check(ack, 1'b0);
        host.write_reg(own, 8'h02, 8'h30, ack);
        check(ack, 1'b1);
        duty(2, 'h30);
        host.half = 4;
        $display("strap test done");
        // clock enable low freezes the modulators, so no sink may move
        held = led_sink_n;
        frz = 0;
        clk_en = 1'b0;
        repeat (256) begin
            @(posedge ref_clk);
            #1;
            if (led_sink_n !== held) frz++;
        end
        clk_en = 1'b1;
        check(frz, 0);
        // blink mode at the fastest rate; the step assertion watches two steps
        host.write_reg(own, 8'h16, 8'h05, ack);
        check(ack, 1'b1);
        repeat (3500) @(posedge ref_clk);
        #1;
        duty(2, 'h30);
        $display("enable and blink test done");
        // software reset: out1 was on, must be back off
        host.soft_reset_call();
        repeat (4) @(posedge ref_clk);
        #1;
        check(led_sink_n, 16'hffff);
        duty(1, 0);
        $display("software reset test done");
        // reset pin after turning out1 on again
        host.write_reg(own, 8'h12, 8'h04, ack);
        duty(1, 256);
        rst_n = 1'b0;
        @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        check(led_sink_n, 16'hffff);
        duty(1, 0);
        $display("reset pin test done");
        stop_test();
    end
endmodule
